// [power_seq_defines.svh]
// register offsets, field positions, masks and reset values for the power sequencer
// assumes inclusion by bare name from the design file
`ifndef POWER_SEQ_DEFINES_SVH
`define POWER_SEQ_DEFINES_SVH
`define PERIPH_RTC 8'h05
`define PERIPH_PWR 8'h06
`define RTC_LOW_OFS 8'h00
`define RTC_HIGH_OFS 8'h04
`define GEN_CTRL_OFS 8'h00
`define WAKE_LOW_OFS 8'h04
`define WAKE_HIGH_OFS 8'h08
`define HOLD_SUP_OFS 8'h0C
`define RES1_SUP_OFS 8'h10
`define RES2_SUP_OFS 8'h14
`define RUN_SUP_OFS 8'h18
`define SUS1_SUP_OFS 8'h1C
`define SUS2_SUP_OFS 8'h20
`define SEQ_STATUS_OFS 8'h24
`define CONV_CTRL_OFS 8'h2C
`define SUPPLY_STATUS_OFS 8'h30
`define CORE_LEVEL_OFS 8'h34
`define PLL_LEVEL_OFS 8'h40
`define GC_DEFAULT_LEVELS 7
`define GC_REAPPLY_RUN 6
`define GC_WIDE_COMPARE 5
`define GC_TIMER_WAKE 4
`define GC_PIN_HIGH 3
`define GC_PIN_WAKE 2
`define GC_SLEEP_START 1
`define GC_SLEEP_CLOCK 0
`define GC_RESET 32'h0000_0008
`define GC_RW_MASK 32'h0000_00BD
`define SUP_DWELL_LSB 16
`define SUP_DWELL_MSB 20
`define SUP_RW_MASK 32'h001F_4333
`define SUP_RESET 32'h0010_0000
`define SUP_RESET_RES1 32'h0010_0020
`define SUP_ENABLE_MASK 32'h0000_0033
`define LEVEL_RESET 32'h0000_0000
`endif

// [power_seq_pkg.sv]
// types shared by the power sequencer
// assumes power_seq_defines.svh sits in the same folder
`default_nettype none
package power_seq_pkg;
  typedef enum logic [2:0] {
    full_run, suspend_stage_one, suspend_stage_two,
    low_power_hold, resume_stage_one, resume_stage_two
  } seq_state_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] periph;
    logic [7:0] offset;
    logic [31:0] wdata;
  } periph_req_t;
endpackage : power_seq_pkg
`default_nettype wire

// [sleep_wake_power_sequencer.sv]
// power-mode sequencer with its 64-bit real-time counter
// assumes a single-cycle 32-bit peripheral access port; wake pin and supply-good are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "power_seq_defines.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - counter low word readable at 0x00, reset zero
// - counter high word readable at 0x04, reset zero
// - counter is peripheral 5, 32-bit accesses
// - sequencer is peripheral 6, 32-bit accesses
// - six per-state supply registers 0x0C..0x20
// - bit 7 selects default or programmed levels
// - bit 6 re-applies run supplies, self-clearing
// - bit 5 selects 64-bit wake compare
// - bit 4 enables timer wake
// - bit 2 enables resume pin wake
// - bit 3 selects pin active level
// - bit 1 starts sleep, self-clearing
// - bit 0 selects sleep clock
// - sleep clock choice only in hold state
// - wake compare only when enabled and asleep
// - per-state log2 dwell field, reset 16
// - hold exits on enabled wake after dwell
// - resume stages wait dwell and supplies good
module sleep_wake_power_sequencer
  import power_seq_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // peripheral access
  input wire periph_req_t req,
  output logic [31:0] rdata,
  output logic rvalid,
  // pins and supplies
  input wire logic resume_pin,
  input wire logic [31:0] supplies_good,
  output logic [31:0] supply_config,
  output logic use_default_levels,
  output logic slow_clock_sel,
  output logic asleep
);

  ////////////////////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] pin_sync;
  logic [31:0] good_meta;
  logic [31:0] good_sync;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_sync <= 2'h0;
      good_meta <= 32'h0000_0000;
      good_sync <= 32'h0000_0000;
    end else begin
      pin_sync <= {pin_sync[0], resume_pin};
      good_meta <= supplies_good;
      good_sync <= good_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  logic [63:0] rtc;
  logic [31:0] gen_ctrl;
  logic [63:0] wake_time;
  logic [31:0] sup [0:5];
  logic [31:0] conv_ctrl, core_level, pll_level;
  logic [63:0] next_rtc;
  logic [31:0] next_gen_ctrl;
  logic [63:0] next_wake_time;
  logic [31:0] next_sup [0:5];
  logic [31:0] next_conv_ctrl, next_core_level, next_pll_level;
  logic rtc_sel, pwr_sel, wr_pwr;
  logic reapply_pulse, next_reapply_pulse;
  logic sleep_req, next_sleep_req;
  seq_state_t state, next_state;

  assign rtc_sel = req.valid && (req.periph == `PERIPH_RTC);
  assign pwr_sel = req.valid && (req.periph == `PERIPH_PWR);
  assign wr_pwr = pwr_sel && req.write;

  always_comb begin
    next_rtc = rtc + 64'h0000_0000_0000_0001;
    next_gen_ctrl = gen_ctrl;
    next_wake_time = wake_time;
    for (int i = 0; i < 6; i++) begin
      next_sup[i] = sup[i];
    end
    next_conv_ctrl = conv_ctrl;
    next_core_level = core_level;
    next_pll_level = pll_level;
    next_reapply_pulse = 1'b0;
    next_sleep_req = 1'b0;
    if (wr_pwr) begin
      if (req.offset == `GEN_CTRL_OFS) begin
        next_gen_ctrl = req.wdata & `GC_RW_MASK;
        next_reapply_pulse = req.wdata[`GC_REAPPLY_RUN];
        next_sleep_req = req.wdata[`GC_SLEEP_START];
      end else if (req.offset == `WAKE_LOW_OFS) begin
        next_wake_time[31:0] = req.wdata;
      end else if (req.offset == `WAKE_HIGH_OFS) begin
        next_wake_time[63:32] = req.wdata;
      end else if (req.offset >= `HOLD_SUP_OFS && req.offset <= `SUS2_SUP_OFS
                   && req.offset[1:0] == 2'h0) begin
        next_sup[3'((req.offset - `HOLD_SUP_OFS) >> 2)] = req.wdata & `SUP_RW_MASK;
      end else if (req.offset == `CONV_CTRL_OFS) begin
        next_conv_ctrl = req.wdata;
      end else if (req.offset == `CORE_LEVEL_OFS) begin
        next_core_level = req.wdata;
      end else if (req.offset == `PLL_LEVEL_OFS) begin
        next_pll_level = req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rtc <= 64'h0000_0000_0000_0000;
      gen_ctrl <= `GC_RESET;
      wake_time <= 64'h0000_0000_0000_0000;
      sup[0] <= `SUP_RESET;
      sup[1] <= `SUP_RESET_RES1;
      sup[2] <= `SUP_RESET;
      sup[3] <= `SUP_RESET;
      sup[4] <= `SUP_RESET;
      sup[5] <= `SUP_RESET;
      conv_ctrl <= `LEVEL_RESET;
      core_level <= `LEVEL_RESET;
      pll_level <= `LEVEL_RESET;
      reapply_pulse <= 1'b0;
      sleep_req <= 1'b0;
    end else begin
      rtc <= next_rtc;
      gen_ctrl <= next_gen_ctrl;
      wake_time <= next_wake_time;
      for (int i = 0; i < 6; i++) begin
        sup[i] <= next_sup[i];
      end
      conv_ctrl <= next_conv_ctrl;
      core_level <= next_core_level;
      pll_level <= next_pll_level;
      reapply_pulse <= next_reapply_pulse;
      sleep_req <= next_sleep_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path
  logic [31:0] next_rdata;
  logic next_rvalid;
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rvalid = req.valid && !req.write && (rtc_sel || pwr_sel);
    if (rtc_sel && req.offset == `RTC_LOW_OFS) begin
      next_rdata = rtc[31:0];
    end else if (rtc_sel && req.offset == `RTC_HIGH_OFS) begin
      next_rdata = rtc[63:32];
    end else if (pwr_sel && req.offset == `GEN_CTRL_OFS) begin
      next_rdata = gen_ctrl;
    end else if (pwr_sel && req.offset == `WAKE_LOW_OFS) begin
      next_rdata = wake_time[31:0];
    end else if (pwr_sel && req.offset == `WAKE_HIGH_OFS) begin
      next_rdata = wake_time[63:32];
    end else if (pwr_sel && req.offset >= `HOLD_SUP_OFS && req.offset <= `SUS2_SUP_OFS
                 && req.offset[1:0] == 2'h0) begin
      next_rdata = sup[3'((req.offset - `HOLD_SUP_OFS) >> 2)];
    end else if (pwr_sel && req.offset == `SEQ_STATUS_OFS) begin
      next_rdata = {29'h0000_0000, state};
    end else if (pwr_sel && req.offset == `CONV_CTRL_OFS) begin
      next_rdata = conv_ctrl;
    end else if (pwr_sel && req.offset == `SUPPLY_STATUS_OFS) begin
      next_rdata = good_sync;
    end else if (pwr_sel && req.offset == `CORE_LEVEL_OFS) begin
      next_rdata = core_level;
    end else if (pwr_sel && req.offset == `PLL_LEVEL_OFS) begin
      next_rdata = pll_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic [31:0] dwell_cnt, next_dwell_cnt;
  logic [31:0] next_supply_config;
  logic next_slow_clock_sel, next_asleep, next_use_default_levels;
  logic [2:0] sidx;
  logic [4:0] dwell_log2;
  logic dwell_done, timer_hit, pin_hit, wake_hit, sup_ok;
  logic [2:0] entry_idx;

  function automatic logic [2:0] state_index(input seq_state_t s);
    case (s)
      low_power_hold: state_index = 3'h0;
      resume_stage_one: state_index = 3'h1;
      resume_stage_two: state_index = 3'h2;
      full_run: state_index = 3'h3;
      suspend_stage_one: state_index = 3'h4;
      default: state_index = 3'h5;
    endcase
  endfunction : state_index

  assign sidx = state_index(state);
  assign dwell_log2 = sup[sidx][`SUP_DWELL_MSB:`SUP_DWELL_LSB];
  assign dwell_done = dwell_cnt >= ((32'h0000_0001 << dwell_log2) - 32'h0000_0001);
  assign timer_hit = gen_ctrl[`GC_TIMER_WAKE] && (state == low_power_hold) &&
    (gen_ctrl[`GC_WIDE_COMPARE] ? (rtc >= wake_time)
                                : (rtc[31:0] >= wake_time[31:0]));
  assign pin_hit = gen_ctrl[`GC_PIN_WAKE] &&
    (pin_sync[1] == gen_ctrl[`GC_PIN_HIGH]);
  assign wake_hit = timer_hit || pin_hit;
  assign sup_ok = ((sup[sidx] & `SUP_ENABLE_MASK & ~good_sync) == 32'h0000_0000);

  always_comb begin
    next_state = state;
    next_dwell_cnt = dwell_cnt + 32'h0000_0001;
    case (state)
      full_run: begin
        if (sleep_req) begin
          next_state = suspend_stage_one;
        end
      end
      suspend_stage_one: begin
        if (dwell_done) begin
          next_state = suspend_stage_two;
        end
      end
      suspend_stage_two: begin
        if (dwell_done) begin
          next_state = low_power_hold;
        end
      end
      low_power_hold: begin
        if (dwell_done && wake_hit) begin
          next_state = resume_stage_one;
        end
      end
      resume_stage_one: begin
        if (dwell_done && sup_ok) begin
          next_state = resume_stage_two;
        end
      end
      default: begin
        if (dwell_done && sup_ok) begin
          next_state = full_run;
        end
      end
    endcase
    if (next_state != state) begin
      next_dwell_cnt = 32'h0000_0000;
    end else if (dwell_done) begin
      next_dwell_cnt = dwell_cnt;
    end
    entry_idx = state_index(next_state);
    next_supply_config = supply_config;
    if (next_state != state || (reapply_pulse && state == full_run)) begin
      next_supply_config = sup[entry_idx];
    end
    next_slow_clock_sel = (next_state == low_power_hold) && !gen_ctrl[`GC_SLEEP_CLOCK];
    next_asleep = (next_state == low_power_hold);
    next_use_default_levels = gen_ctrl[`GC_DEFAULT_LEVELS];
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= full_run;
      dwell_cnt <= 32'h0000_0000;
      supply_config <= `SUP_RESET;
      slow_clock_sel <= 1'b0;
      asleep <= 1'b0;
      use_default_levels <= 1'b0;
      rdata <= 32'h0000_0000;
      rvalid <= 1'b0;
    end else begin
      state <= next_state;
      dwell_cnt <= next_dwell_cnt;
      supply_config <= next_supply_config;
      slow_clock_sel <= next_slow_clock_sel;
      asleep <= next_asleep;
      use_default_levels <= next_use_default_levels;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_sleep_cmd;
    state == full_run && sleep_req;
  endsequence
  sequence s_suspend;
    state == suspend_stage_one;
  endsequence
  chk_sleep_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_sleep_cmd |=> s_suspend) else $error("sleep request did not start suspend");
  chk_self_clear: assert property (@(posedge sys_clk) disable iff (!resetn)
    reapply_pulse |=> !reapply_pulse || $past(wr_pwr)) else $error("reapply did not clear");
  chk_slow_clock: assert property (@(posedge sys_clk) disable iff (!resetn)
    slow_clock_sel |-> state == low_power_hold) else $error("slow clock outside hold");
  chk_hold_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == low_power_hold && !wake_hit |=> state == low_power_hold)
    else $error("hold left without wake");
  chk_resume_good: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == resume_stage_one && !sup_ok |=> state == resume_stage_one)
    else $error("resume advanced with bad supply");
  chk_rtc_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> rtc == $past(rtc) + 64'h0000_0000_0000_0001) else $error("counter did not step");
  chk_timer_gate: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == low_power_hold && dwell_done && gen_ctrl[`GC_TIMER_WAKE] &&
    !gen_ctrl[`GC_WIDE_COMPARE] && rtc[31:0] >= wake_time[31:0]
    |=> state == resume_stage_one)
    else $error("timer match did not wake");
  chk_wide_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == low_power_hold && gen_ctrl[`GC_WIDE_COMPARE] && rtc < wake_time && !pin_hit
    |=> state == low_power_hold)
    else $error("wide compare woke early");
  chk_entry_apply: assert property (@(posedge sys_clk) disable iff (!resetn)
    state == suspend_stage_one && $past(state) == full_run |-> supply_config == sup[4])
    else $error("suspend supplies not applied");
  chk_levels: assert property (@(posedge sys_clk) disable iff (!resetn)
    1'b1 |=> use_default_levels == $past(gen_ctrl[`GC_DEFAULT_LEVELS]))
    else $error("level select wrong");

endmodule : sleep_wake_power_sequencer
`default_nettype wire

// [sleep_wake_power_sequencer_test.sv]
// self-checking bench for the power sequencer and its real-time counter
// assumes power_seq_pkg and the sequencer are compiled first
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_power_sequencer_test;
  import power_seq_pkg::*;
  typedef struct {logic [7:0] o; logic [31:0] w; logic [31:0] e;} row_t;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  periph_req_t req = '0;
  logic resume_pin = 1'b0;
  logic [31:0] supplies_good = 32'hFFFF_FFFF;
  logic [31:0] rdata;
  logic [31:0] supply_config;
  logic rvalid, use_default_levels, slow_clock_sel, asleep;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int take, t1;
  logic [31:0] d, d2;
  row_t rows [14] = '{
    '{8'h04, 32'h1234_5678, 32'h1234_5678}, '{8'h08, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
    '{8'h0C, 32'hFFE0_0033, 32'h0000_0033}, '{8'h10, 32'h0000_0021, 32'h0000_0021},
    '{8'h14, 32'h0000_0011, 32'h0000_0011}, '{8'h18, 32'h0000_4001, 32'h0000_4001},
    '{8'h1C, 32'h0000_0100, 32'h0000_0100}, '{8'h20, 32'h0000_0200, 32'h0000_0200},
    '{8'h24, 32'h0000_0005, 32'h0000_0000}, '{8'h28, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h2C, 32'h1234_5678, 32'h1234_5678}, '{8'h34, 32'h0000_00AA, 32'h0000_00AA},
    '{8'h40, 32'h0000_0055, 32'h0000_0055}, '{8'h00, 32'hFFFF_FF08, 32'h0000_0008}};

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  sleep_wake_power_sequencer u_sleep_wake_power_sequencer (
    .sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata), .rvalid(rvalid),
    .resume_pin(resume_pin), .supplies_good(supplies_good), .supply_config(supply_config),
    .use_default_levels(use_default_levels), .slow_clock_sel(slow_clock_sel), .asleep(asleep));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tdone(input string nm);
    $display("test %s done", nm);
  endtask : tdone

  // one access: drive at falling edge, taken at next rising edge, bounded wait for read data
  task automatic acc(input logic w, input logic [7:0] p, input logic [7:0] o,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(negedge sys_clk);
    req = '{1'b1, w, p, o, wd};
    take = cyc;
    @(negedge sys_clk);
    req.valid = 1'b0;
    rd = '0;
    if (!w) begin
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
        @(negedge sys_clk);
        n++;
      end
      if (n == 4) begin
        fail_count++;
        final_report();
      end
      rd = rdata;
    end
  endtask : acc

  task automatic wait_asleep(input logic v);
    int n;
    n = 0;
    while (asleep !== v && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 300) begin
      fail_count++;
      final_report();
    end
  endtask : wait_asleep

  task automatic wait_run();
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h1;
    while (s !== 32'h0 && n < 50) begin
      acc(1'b0, 8'h06, 8'h24, 32'h0, s);
      n++;
    end
    if (n == 50) begin
      fail_count++;
      final_report();
    end
  endtask : wait_run

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    chk("reset cfg", supply_config, 32'h0010_0000);
    chk("reset flags", {29'h0, asleep, slow_clock_sel, use_default_levels}, 32'h0);
    acc(1'b0, 8'h06, 8'h00, 32'h0, d);
    chk("gen ctrl", d, 32'h0000_0008);
    acc(1'b0, 8'h06, 8'h0C, 32'h0, d);
    chk("hold reset", d, 32'h0010_0000);
    acc(1'b0, 8'h06, 8'h10, 32'h0, d);
    chk("res1 reset", d, 32'h0010_0020);
    acc(1'b0, 8'h05, 8'h04, 32'h0, d);
    chk("rtc high", d, 32'h0);
    acc(1'b0, 8'h05, 8'h00, 32'h0, d);
    t1 = take;
    acc(1'b0, 8'h05, 8'h00, 32'h0, d2);
    chk("rtc step", d2 - d, 32'(take - t1));
    acc(1'b1, 8'h05, 8'h04, 32'hFFFF_FFFF, d);
    acc(1'b0, 8'h05, 8'h04, 32'h0, d);
    chk("rtc ro", d, 32'h0);
    tdone("reset");
    foreach (rows[i]) begin
      acc(1'b1, 8'h06, rows[i].o, rows[i].w, d);
      acc(1'b0, 8'h06, rows[i].o, 32'h0, d);
      chk("reg", d, rows[i].e);
    end
    acc(1'b1, 8'h07, 8'h04, 32'h0, d);
    acc(1'b0, 8'h06, 8'h04, 32'h0, d);
    chk("other periph", d, 32'h1234_5678);
    tdone("registers");
    acc(1'b1, 8'h06, 8'h00, 32'h0000_0048, d);
    repeat (2) @(negedge sys_clk);
    chk("reapply", supply_config, 32'h0000_4001);
    acc(1'b0, 8'h06, 8'h00, 32'h0, d);
    chk("self clear", d, 32'h0000_0008);
    tdone("reapply");
    acc(1'b1, 8'h06, 8'h00, 32'h0000_000E, d);
    wait_asleep(1'b1);
    chk("slow clk", {31'h0, slow_clock_sel}, 32'h1);
    chk("hold cfg", supply_config, 32'h0000_0033);
    repeat (20) @(negedge sys_clk);
    chk("stay", {31'h0, asleep}, 32'h1);
    acc(1'b0, 8'h06, 8'h24, 32'h0, d);
    chk("status hold", d, 32'h3);
    acc(1'b0, 8'h06, 8'h00, 32'h0, d);
    chk("start clear", d, 32'h0000_000C);
    supplies_good = 32'h0;
    resume_pin = 1'b1;
    wait_asleep(1'b0);
    chk("clk off", {31'h0, slow_clock_sel}, 32'h0);
    repeat (20) @(negedge sys_clk);
    acc(1'b0, 8'h06, 8'h24, 32'h0, d);
    chk("res1 wait", d, 32'h4);
    chk("res1 cfg", supply_config, 32'h0000_0021);
    supplies_good = 32'hFFFF_FFFF;
    resume_pin = 1'b0;
    wait_run();
    chk("run cfg", supply_config, 32'h0000_4001);
    tdone("pin wake");
    acc(1'b0, 8'h05, 8'h00, 32'h0, d);
    acc(1'b1, 8'h06, 8'h04, d + 32'h0000_012C, d2);
    acc(1'b1, 8'h06, 8'h08, 32'h1, d2);
    acc(1'b1, 8'h06, 8'h00, 32'h0000_00BB, d2);
    wait_asleep(1'b1);
    chk("fast clk", {31'h0, slow_clock_sel}, 32'h0);
    chk("dflt lvl", {31'h0, use_default_levels}, 32'h1);
    repeat (400) @(negedge sys_clk);
    chk("wide hold", {31'h0, asleep}, 32'h1);
    acc(1'b1, 8'h06, 8'h08, 32'h0, d2);
    t1 = take;
    wait_asleep(1'b0);
    chk("wake prompt", {31'h0, (cyc - t1) < 8}, 32'h1);
    acc(1'b0, 8'h05, 8'h00, 32'h0, d2);
    chk("timer wake", {31'h0, d2 >= d + 32'h0000_012C}, 32'h1);
    wait_run();
    acc(1'b0, 8'h05, 8'h00, 32'h0, d);
    acc(1'b1, 8'h06, 8'h04, d + 32'h0000_0064, d2);
    acc(1'b1, 8'h06, 8'h08, 32'h1, d2);
    acc(1'b1, 8'h06, 8'h00, 32'h0000_001A, d2);
    wait_asleep(1'b1);
    chk("dflt off", {31'h0, use_default_levels}, 32'h0);
    wait_asleep(1'b0);
    acc(1'b0, 8'h05, 8'h00, 32'h0, d2);
    chk("narrow wake", {31'h0, d2 >= d + 32'h0000_0064}, 32'h1);
    tdone("timer wake");
    wait_run();
    resume_pin = 1'b1;
    acc(1'b1, 8'h06, 8'h00, 32'h0000_0006, d2);
    wait_asleep(1'b1);
    repeat (20) @(negedge sys_clk);
    chk("low stay", {31'h0, asleep}, 32'h1);
    chk("low slow clk", {31'h0, slow_clock_sel}, 32'h1);
    resume_pin = 1'b0;
    wait_asleep(1'b0);
    wait_run();
    chk("low run cfg", supply_config, 32'h0000_4001);
    tdone("pin low wake");
    resume_pin = 1'b1;
    acc(1'b1, 8'h06, 8'h00, 32'h0000_0006, d2);
    wait_asleep(1'b1);
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("rst flags", {30'h0, asleep, slow_clock_sel}, 32'h0);
    chk("rst cfg", supply_config, 32'h0010_0000);
    resetn = 1'b1;
    acc(1'b0, 8'h06, 8'h00, 32'h0, d);
    chk("rst gen ctrl", d, 32'h0000_0008);
    acc(1'b0, 8'h06, 8'h0C, 32'h0, d);
    chk("rst hold", d, 32'h0010_0000);
    acc(1'b0, 8'h05, 8'h00, 32'h0, d);
    chk("rst rtc", {31'h0, d < 32'h0000_0010}, 32'h1);
    tdone("mid reset");
    final_report();
  end
endmodule : sleep_wake_power_sequencer_test
`default_nettype wire
